// [rtl/buffered_ram_port_cfg.svh]
// Functional notes
// - transparent mode: transfer starts first edge after ack or grant goes low.
// - buffered mode: engine transfer starts on the edge that drives grant low; host transfers leave grant high.
// - buffered mode: every host and engine access uses the buffered bus.
// - transparent mode: buffered access only if route input low after request.
// - narrow strap low: each access becomes two consecutive byte accesses.
// - narrow mode: top address bit selects upper or lower byte.
// - narrow mode: both bytes use upper data lines; lower lines unused.
// - direction strap high: rd_wr high reads; low: rd_wr low reads.
// - no-stall strap high selects waited host handshake, low zero-wait; code applies this in buffered mode only, transparent mode always acks.
// - parity line used only with 17/9-bit RAM; enables parity gen/check.
// - one access sequence serves host and engine in both modes.
// - buffered bus is separate from the host processor bus.
// - read end: select and read strobe rise on the same edge, except after the first byte in narrow mode.
// - write data driven after an edge, released on a later edge.
// - on-chip choose low selects internal RAM, high off-chip RAM.
// - read strobe asserted on every read; bus data ignored if on-chip.
// - write strobe pulsed only when off-chip RAM chosen.
`ifndef BUFFERED_RAM_PORT_CFG_SVH
`define BUFFERED_RAM_PORT_CFG_SVH

`define BRP_HALF_CYCLES   4
`define BRP_LAST_PHASE    2'h3
`define BRP_OE_PHASE      2'h1
`define BRP_WR_PHASE      2'h2
`define BRP_ROUTE_WAIT    2'h3
`define BRP_TOP_BIT       15
`define BRP_PAR_BIT       16
`define BRP_UPPER_HALF    1'b1
`define BRP_ODD_PARITY    1'b1

`endif

// [rtl/buffered_ram_port_pkg.sv]
package buffered_ram_port_pkg;

    typedef struct packed {
        logic        write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } eng_req_s;

    typedef struct packed {
        logic        rd_wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } host_req_s;

    typedef struct packed {
        logic        select_n;
        logic        read_strobe_n;
        logic        write_strobe_n;
        logic [15:0] addr;
        logic [16:0] data;
        logic        upper_oe;
        logic        lower_oe;
        logic        parity_oe;
    } ram_pins_s;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_ROUTE  = 5'h02,
        ST_GRANT  = 5'h04,
        ST_ACCESS = 5'h08,
        ST_FINISH = 5'h10
    } port_state_e;

endpackage

// [rtl/pin_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int          W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_q <= RST;
            sync_q <= RST;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule // pin_sync
`default_nettype wire

// [rtl/lane_parity.sv]
`timescale 1ns/100ps
`default_nettype none
`include "buffered_ram_port_cfg.svh"
module lane_parity (
    input  wire logic [15:0] data_i,
    input  wire logic        narrow_i,
    input  wire logic        upper_i,
    output logic             parity_o
);
    logic [15:0] lane;

    // narrow mode covers only the byte on the wire
    always_comb begin
        lane = data_i;
        if (narrow_i) begin
            lane = upper_i ? {8'h00, data_i[15:8]} : {8'h00, data_i[7:0]};
        end
        parity_o = (^lane) ^ `BRP_ODD_PARITY;
    end
endmodule // lane_parity
`default_nettype wire

// [rtl/buffered_ram_port.sv]
`timescale 1ns/100ps
`default_nettype none
`include "buffered_ram_port_cfg.svh"
module buffered_ram_port
    import buffered_ram_port_pkg::*;
(
    input  wire logic      clk_i,
    input  wire logic      rst_n_i,
    input  wire logic      buffered_mode_i,
    input  wire logic      narrow_ram_select_n_i,
    input  wire logic      direction_sense_i,
    input  wire logic      no_stall_i,
    input  wire logic      parity_enable_i,
    input  wire logic      onchip_ram_choose_n_i,
    input  wire logic      host_memory_route_in_n_i,
    input  wire logic      eng_req_i,
    input  wire eng_req_s  eng_cmd_i,
    input  wire logic      host_req_i,
    input  wire host_req_s host_cmd_i,
    input  wire logic [16:0] ram_data_i,
    output ram_pins_s      ram_o,
    output logic           io_grant_n_o,
    output logic           host_memory_request_out_n_o,
    output logic           host_transfer_ack_n_o,
    output logic [15:0]    rdata_o,
    output logic           eng_done_o,
    output logic           host_done_o,
    output logic           onchip_hit_o,
    output logic           external_route_o,
    output logic           parity_err_o
);
    logic [5:0]  ctl_s;
    logic [16:0] din_s;
    logic        buf_s, narrow_n_s, dir_s, nostall_s, choose_n_s, route_n_s;

    pin_sync #(.W(6), .RST(6'h3f)) u_ctl_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     ({buffered_mode_i, narrow_ram_select_n_i, direction_sense_i,
                   no_stall_i, onchip_ram_choose_n_i,
                   host_memory_route_in_n_i}),
        .q_o     (ctl_s)
    );

    pin_sync #(.W(17), .RST(17'h00000)) u_data_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (ram_data_i),
        .q_o     (din_s)
    );

    assign {buf_s, narrow_n_s, dir_s, nostall_s, choose_n_s, route_n_s} = ctl_s;

    port_state_e state_q, state_d;
    logic [1:0]  phase_q, phase_d;
    logic [1:0]  wait_q, wait_d;
    logic        half_q, half_d;
    logic        host_q, host_d;
    logic        wr_q, wr_d;
    logic        narrow_q, narrow_d;
    logic        onchip_q, onchip_d;
    logic        ext_q, ext_d;
    logic [15:0] addr_q, addr_d;
    logic [15:0] wdata_q, wdata_d;
    logic [15:0] rdata_q, rdata_d;
    logic        cap_q, cap_d;
    logic        cap_hi_q, cap_hi_d;
    logic        perr_q, perr_d;
    ram_pins_s   pins_q, pins_d;
    logic        grant_n_q, grant_n_d;
    logic        mreq_n_q, mreq_n_d;
    logic        ack_n_q, ack_n_d;
    logic        edone_q, edone_d;
    logic        hdone_q, hdone_d;
    logic        wpar, rpar;
    logic        access_d, rd_strobe, wr_strobe;

    lane_parity u_wpar (
        .data_i   (wdata_q),
        .narrow_i (narrow_q),
        .upper_i  (half_d == `BRP_UPPER_HALF),
        .parity_o (wpar)
    );

    lane_parity u_rpar (
        .data_i   (din_s[15:0]),
        .narrow_i (narrow_q),
        .upper_i  (1'b1),
        .parity_o (rpar)
    );

    // sequencer: one path for host and engine alike
    always_comb begin
        state_d  = state_q;
        phase_d  = phase_q;
        wait_d   = wait_q;
        half_d   = half_q;
        host_d   = host_q;
        wr_d     = wr_q;
        narrow_d = narrow_q;
        onchip_d = onchip_q;
        ext_d    = ext_q;
        addr_d   = addr_q;
        wdata_d  = wdata_q;
        grant_n_d = grant_n_q;
        mreq_n_d  = mreq_n_q;
        ack_n_d   = 1'b1;
        edone_d   = 1'b0;
        hdone_d   = 1'b0;
        case (state_q)
            ST_IDLE: begin
                phase_d = 2'h0;
                ext_d   = 1'b0;
                if (eng_req_i || host_req_i) begin
                    // engine wins when both ask in one cycle
                    host_d   = !eng_req_i;
                    wr_d     = eng_req_i ? eng_cmd_i.write
                             : (dir_s ? !host_cmd_i.rd_wr
                                      : host_cmd_i.rd_wr);
                    addr_d   = eng_req_i ? eng_cmd_i.addr : host_cmd_i.addr;
                    wdata_d  = eng_req_i ? eng_cmd_i.wdata : host_cmd_i.wdata;
                    narrow_d = !narrow_n_s;
                    half_d   = `BRP_UPPER_HALF;
                    onchip_d = !choose_n_s;
                    if (buf_s) begin
                        state_d   = ST_ACCESS;
                        grant_n_d = !eng_req_i ? grant_n_q : 1'b0;
                    end else begin
                        state_d  = ST_ROUTE;
                        mreq_n_d = 1'b0;
                        wait_d   = 2'h0;
                    end
                end
            end
            ST_ROUTE: begin
                // route input needs the sync delay before it is trusted
                wait_d = wait_q + 2'h1;
                if (wait_q == `BRP_ROUTE_WAIT) begin
                    ext_d   = route_n_s;
                    state_d = ST_GRANT;
                    if (host_q) begin
                        ack_n_d = 1'b0;
                    end else begin
                        grant_n_d = 1'b0;
                    end
                end
            end
            ST_GRANT: begin
                onchip_d = !choose_n_s;
                state_d  = ext_q ? ST_FINISH : ST_ACCESS;
            end
            ST_ACCESS: begin
                phase_d = phase_q + 2'h1;
                if (phase_q == `BRP_LAST_PHASE) begin
                    if (narrow_q && half_q == `BRP_UPPER_HALF) begin
                        half_d = !`BRP_UPPER_HALF;
                    end else begin
                        state_d = ST_FINISH;
                    end
                end
            end
            ST_FINISH: begin
                state_d   = ST_IDLE;
                grant_n_d = 1'b1;
                mreq_n_d  = 1'b1;
                edone_d   = !host_q;
                hdone_d   = host_q;
                // waited handshake acknowledges at the end
                ack_n_d   = !(host_q && buf_s && nostall_s);
            end
            default: begin
                state_d   = ST_IDLE;
                grant_n_d = 1'b1;
                mreq_n_d  = 1'b1;
            end
        endcase
    end

    // pin image, computed from next state so pins come from flops
    always_comb begin
        access_d  = (state_d == ST_ACCESS);
        rd_strobe = access_d && !wr_d && (phase_d >= `BRP_OE_PHASE);
        wr_strobe = access_d && wr_d && (phase_d == `BRP_WR_PHASE);
        pins_d = pins_q;
        pins_d.select_n       = !access_d;
        pins_d.read_strobe_n  = !rd_strobe;
        pins_d.write_strobe_n = !(wr_strobe && !onchip_d);
        pins_d.upper_oe       = access_d && wr_d;
        pins_d.lower_oe       = access_d && wr_d && !narrow_d;
        pins_d.parity_oe      = access_d && wr_d && parity_enable_i;
        if (access_d) begin
            pins_d.addr = addr_d;
            if (narrow_d) begin
                pins_d.addr[`BRP_TOP_BIT] = half_d;
                pins_d.data[15:8] = (half_d == `BRP_UPPER_HALF)
                                  ? wdata_d[15:8] : wdata_d[7:0];
                pins_d.data[7:0]  = 8'h00;
            end else begin
                pins_d.data[15:0] = wdata_d;
            end
            pins_d.data[`BRP_PAR_BIT] = wpar;
        end
    end

    // read capture one cycle after each half, from synced data lines
    always_comb begin
        cap_d    = (state_q == ST_ACCESS) && !wr_q
                && (phase_q == `BRP_LAST_PHASE);
        cap_hi_d = narrow_q && (half_q == `BRP_UPPER_HALF);
        rdata_d  = rdata_q;
        perr_d   = (state_q == ST_IDLE) ? 1'b0 : perr_q;
        if (cap_q && !onchip_q) begin
            if (!narrow_q) begin
                rdata_d = din_s[15:0];
            end else if (cap_hi_q) begin
                rdata_d[15:8] = din_s[15:8];
            end else begin
                rdata_d[7:0] = din_s[15:8];
            end
            if (parity_enable_i
                && (din_s[`BRP_PAR_BIT] != (narrow_q ? rpar
                    : ((^din_s[15:0]) ^ `BRP_ODD_PARITY)))) begin
                perr_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q   <= ST_IDLE;
            phase_q   <= 2'h0;
            wait_q    <= 2'h0;
            half_q    <= 1'b0;
            host_q    <= 1'b0;
            wr_q      <= 1'b0;
            narrow_q  <= 1'b0;
            onchip_q  <= 1'b0;
            ext_q     <= 1'b0;
            addr_q    <= 16'h0000;
            wdata_q   <= 16'h0000;
            rdata_q   <= 16'h0000;
            cap_q     <= 1'b0;
            cap_hi_q  <= 1'b0;
            perr_q    <= 1'b0;
            pins_q    <= '{select_n: 1'b1, read_strobe_n: 1'b1,
                           write_strobe_n: 1'b1, default: '0};
            grant_n_q <= 1'b1;
            mreq_n_q  <= 1'b1;
            ack_n_q   <= 1'b1;
            edone_q   <= 1'b0;
            hdone_q   <= 1'b0;
        end else begin
            state_q   <= state_d;
            phase_q   <= phase_d;
            wait_q    <= wait_d;
            half_q    <= half_d;
            host_q    <= host_d;
            wr_q      <= wr_d;
            narrow_q  <= narrow_d;
            onchip_q  <= onchip_d;
            ext_q     <= ext_d;
            addr_q    <= addr_d;
            wdata_q   <= wdata_d;
            rdata_q   <= rdata_d;
            cap_q     <= cap_d;
            cap_hi_q  <= cap_hi_d;
            perr_q    <= perr_d;
            pins_q    <= pins_d;
            grant_n_q <= grant_n_d;
            mreq_n_q  <= mreq_n_d;
            ack_n_q   <= ack_n_d;
            edone_q   <= edone_d;
            hdone_q   <= hdone_d;
        end
    end

    assign ram_o                       = pins_q;
    assign io_grant_n_o                = grant_n_q;
    assign host_memory_request_out_n_o = mreq_n_q;
    assign host_transfer_ack_n_o       = ack_n_q;
    assign rdata_o                     = rdata_q;
    assign eng_done_o                  = edone_q;
    assign host_done_o                 = hdone_q;
    assign onchip_hit_o                = onchip_q;
    assign external_route_o            = ext_q;
    assign parity_err_o                = perr_q;
endmodule // buffered_ram_port
`default_nettype wire

// [sim/buffered_ram_port_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
module buffered_ram_port_asserts
    import buffered_ram_port_pkg::*;
(
    input  wire logic      clk_i,
    input  wire logic      rst_n_i,
    input  wire logic      buffered_mode_i,
    input  wire logic      narrow_ram_select_n_i,
    input  wire logic      host_memory_route_in_n_i,
    input  wire ram_pins_s ram_o,
    input  wire logic      io_grant_n_o,
    input  wire logic      host_transfer_ack_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_start_buf;
        $fell(io_grant_n_o) && buffered_mode_i |-> $fell(ram_o.select_n);
    endproperty
    a_start_buf: assert property (p_start_buf)
        else $error("select not started with grant");
    property p_start_tr;
        ($fell(io_grant_n_o) || $fell(host_transfer_ack_n_o)) &&
        !buffered_mode_i && !host_memory_route_in_n_i
        |=> $fell(ram_o.select_n);
    endproperty
    a_start_tr: assert property (p_start_tr)
        else $error("transparent access not started next edge");
    property p_sel_word;
        $fell(ram_o.select_n) && narrow_ram_select_n_i
        |-> !ram_o.select_n [*4] ##1 ram_o.select_n;
    endproperty
    a_sel_word: assert property (p_sel_word)
        else $error("word select length wrong");
    property p_sel_byte;
        $fell(ram_o.select_n) && !narrow_ram_select_n_i
        |-> !ram_o.select_n [*8] ##1 ram_o.select_n;
    endproperty
    a_sel_byte: assert property (p_sel_byte)
        else $error("byte select length wrong");
    property p_read_end;
        $rose(ram_o.read_strobe_n) && narrow_ram_select_n_i
        |-> $rose(ram_o.select_n);
    endproperty
    a_read_end: assert property (p_read_end)
        else $error("read strobe and select not released together");
    property p_read_len;
        $fell(ram_o.read_strobe_n)
        |-> !ram_o.read_strobe_n [*3] ##1 ram_o.read_strobe_n;
    endproperty
    a_read_len: assert property (p_read_len)
        else $error("read strobe length wrong");
    property p_wr_data;
        !ram_o.write_strobe_n |-> ram_o.upper_oe && !ram_o.select_n;
    endproperty
    a_wr_data: assert property (p_wr_data)
        else $error("write strobe without driven data");
    property p_oe_sel;
        ram_o.upper_oe || ram_o.lower_oe || ram_o.parity_oe
        |-> !ram_o.select_n && ram_o.read_strobe_n;
    endproperty
    a_oe_sel: assert property (p_oe_sel)
        else $error("data driven outside a write");
    property p_no_both;
        !(!ram_o.read_strobe_n && !ram_o.write_strobe_n);
    endproperty
    a_no_both: assert property (p_no_both)
        else $error("both strobes active");
    property p_addr_stable;
        !ram_o.select_n && !$past(ram_o.select_n)
        |-> $stable(ram_o.addr[14:0]);
    endproperty
    a_addr_stable: assert property (p_addr_stable)
        else $error("address moved during access");
    property p_narrow_lanes;
        !narrow_ram_select_n_i && !$past(narrow_ram_select_n_i, 3)
        |-> !ram_o.lower_oe;
    endproperty
    a_narrow_lanes: assert property (p_narrow_lanes)
        else $error("lower lanes driven in byte mode");
    property p_route_off;
        !buffered_mode_i && host_memory_route_in_n_i &&
        $past(host_memory_route_in_n_i, 3) |-> ram_o.select_n;
    endproperty
    a_route_off: assert property (p_route_off)
        else $error("buffered bus used while routed away");
endmodule // buffered_ram_port_asserts

bind buffered_ram_port buffered_ram_port_asserts u_asserts (
    .clk_i                    (clk_i),
    .rst_n_i                  (rst_n_i),
    .buffered_mode_i          (buffered_mode_i),
    .narrow_ram_select_n_i    (narrow_ram_select_n_i),
    .host_memory_route_in_n_i (host_memory_route_in_n_i),
    .ram_o                    (ram_o),
    .io_grant_n_o             (io_grant_n_o),
    .host_transfer_ack_n_o    (host_transfer_ack_n_o)
);
`default_nettype wire

// [sim/sram_model.sv]
`timescale 1ns/100ps
`default_nettype none
module sram_model
    import buffered_ram_port_pkg::*;
(
    input  wire logic      clk_i,
    input  wire ram_pins_s ram_i,
    input  wire logic      slow_i,
    input  wire logic      corrupt_i,
    output logic    [16:0] data_o
);
    logic [16:0] mem [0:65535];
    logic [16:0] last_q = 17'h0;
    logic        rd_q = 1'b0;
    wire  logic  rd = !ram_i.select_n && !ram_i.read_strobe_n;

    always @(posedge clk_i) begin
        rd_q <= rd;
        if (!ram_i.select_n && !ram_i.write_strobe_n) begin
            if (ram_i.upper_oe) mem[ram_i.addr][15:8] <= ram_i.data[15:8];
            if (ram_i.lower_oe) mem[ram_i.addr][7:0] <= ram_i.data[7:0];
            if (ram_i.parity_oe) mem[ram_i.addr][16] <= ram_i.data[16];
        end
        if (rd) last_q <= data_o;
    end
    // released lines show the inverse of the last value, never a stale copy
    always @* begin
        if (rd && (!slow_i || rd_q)) data_o = mem[ram_i.addr] ^ {corrupt_i, 16'h0};
        else data_o = ~last_q;
    end
endmodule // sram_model
`default_nettype wire

// [sim/test_buffered_ram_port.sv]
`timescale 1ns/100ps
`default_nettype none
module test_buffered_ram_port;
    import buffered_ram_port_pkg::*;
    logic clk_i = 0, rst_n_i = 0, buf_m = 1, narrow_n = 1, dir = 1;
    logic nostall = 1, onchip_n = 1, route_n = 0, eng_req = 0, host_req = 0;
    logic slow = 0, corrupt = 0, grant_n, req_out_n, ack_n, e_done, h_done;
    logic hit, ext, perr, par_en = 1;
    logic [16:0] rdat;
    logic [15:0] rdata;
    eng_req_s    ecmd = '0;
    host_req_s   hcmd = '0;
    ram_pins_s   ram;
    int num_errors = 0, compares = 0, cyc = 0, wr_c, rd_c, sel_c, lo_c, ack_c;
    // error and route flags only stand until idle, so they are counted
    int pe_c, ex_c, gr_c, rq_c;

    always #20 clk_i = ~clk_i;

    buffered_ram_port u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .buffered_mode_i(buf_m), .narrow_ram_select_n_i(narrow_n),
        .direction_sense_i(dir), .no_stall_i(nostall), .parity_enable_i(par_en),
        .onchip_ram_choose_n_i(onchip_n), .host_memory_route_in_n_i(route_n),
        .eng_req_i(eng_req), .eng_cmd_i(ecmd), .host_req_i(host_req),
        .host_cmd_i(hcmd), .ram_data_i(rdat), .ram_o(ram),
        .io_grant_n_o(grant_n), .host_memory_request_out_n_o(req_out_n),
        .host_transfer_ack_n_o(ack_n), .rdata_o(rdata), .eng_done_o(e_done),
        .host_done_o(h_done), .onchip_hit_o(hit), .external_route_o(ext),
        .parity_err_o(perr));
    sram_model u_ram (.clk_i(clk_i), .ram_i(ram), .slow_i(slow),
        .corrupt_i(corrupt), .data_o(rdat));

    task report_and_stop;
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // cycle counts per access; the bench never looks at the design's view
    always @(posedge clk_i) begin
        cyc++;
        wr_c += ram.write_strobe_n ? 0 : 1;
        rd_c += ram.read_strobe_n ? 0 : 1;
        sel_c += ram.select_n ? 0 : 1;
        lo_c += ram.lower_oe ? 1 : 0;
        ack_c += ack_n ? 0 : 1;
        pe_c += perr ? 1 : 0;
        ex_c += ext ? 1 : 0;
        gr_c += grant_n ? 0 : 1;
        rq_c += req_out_n ? 0 : 1;
        if (cyc > 3000) begin
            num_errors++;
            report_and_stop();
        end
    end

    task check(input string what, input logic [31:0] exp, got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task settle;
        repeat (4) @(negedge clk_i);
    endtask

    task access(input logic host, wr, input logic [15:0] a, d, input int lat);
        int n;
        @(negedge clk_i);
        wr_c = 0; rd_c = 0; sel_c = 0; lo_c = 0; ack_c = 0; n = 0;
        pe_c = 0; ex_c = 0; gr_c = 0; rq_c = 0;
        if (host) begin
            hcmd = '{wr ? ~dir : dir, a, d};
            host_req = 1;
        end else begin
            ecmd = '{wr, a, d};
            eng_req = 1;
        end
        do begin
            @(posedge clk_i);
            n++;
            #1;
        end while (!(e_done | h_done) && n < 40);
        @(negedge clk_i);
        eng_req = 0;
        host_req = 0;
        check("done seen", 1, n < 40);
        if (lat > 0) check("latency", lat, n);
        repeat (2) @(negedge clk_i);
    endtask

    initial begin
        repeat (4) @(negedge clk_i);
        rst_n_i = 1;
        settle();
        access(0, 1, 16'h0123, 16'hbeef, 6);
        check("write pulses", 1, wr_c);
        check("select cycles", 4, sel_c);
        check("grant cycles", 5, gr_c);
        check("request idle", 0, rq_c);
        access(0, 0, 16'h0123, 16'h0, 6);
        check("rdata", 16'hbeef, rdata);
        check("read cycles", 3, rd_c);
        $display("buffered word test over");
        for (int k = 0; k < 2; k++) begin
            dir = k[0];
            settle();
            access(1, 1, 16'h0200, 16'h1111 * (k + 3), 6);
            check("ack pulses", 1, ack_c);
            access(1, 0, 16'h0200, 16'h0, 6);
            check("host rdata", 16'h1111 * (k + 3), rdata);
        end
        nostall = 0;
        settle();
        access(1, 0, 16'h0200, 16'h0, 6);
        check("zero wait ack", 0, ack_c);
        nostall = 1;
        $display("host direction test over");
        onchip_n = 0;
        settle();
        access(0, 1, 16'h0123, 16'h0f0f, 6);
        check("onchip write pulses", 0, wr_c);
        check("ram kept", 16'hbeef, u_ram.mem[16'h0123][15:0]);
        access(0, 0, 16'h0123, 16'h0, 6);
        check("onchip read cycles", 3, rd_c);
        check("onchip hit", 1, hit);
        check("rdata held", 16'h4444, rdata);
        onchip_n = 1;
        narrow_n = 0;
        settle();
        $display("onchip test over");
        access(0, 1, 16'h2345, 16'ha55a, 10);
        check("byte write pulses", 2, wr_c);
        check("byte select cycles", 8, sel_c);
        check("lower lanes", 0, lo_c);
        check("upper byte", 8'ha5, u_ram.mem[16'ha345][15:8]);
        check("lower byte", 8'h5a, u_ram.mem[16'h2345][15:8]);
        access(0, 0, 16'h2345, 16'h0, 10);
        check("byte rdata", 16'ha55a, rdata);
        check("parity clean", 0, pe_c > 0);
        corrupt = 1;
        access(0, 0, 16'h2345, 16'h0, 10);
        check("parity error", 1, pe_c > 0);
        narrow_n = 1;
        slow = 1;
        par_en = 0;
        settle();
        $display("byte mode test over");
        access(0, 0, 16'h0123, 16'h0, 6);
        check("slow rdata", 16'hbeef, rdata);
        check("parity off", 0, pe_c > 0);
        corrupt = 0;
        par_en = 1;
        slow = 0;
        buf_m = 0;
        settle();
        access(1, 1, 16'h0300, 16'hc3c3, 11);
        check("request cycles", 10, rq_c);
        access(1, 0, 16'h0300, 16'h0, 11);
        check("transparent rdata", 16'hc3c3, rdata);
        route_n = 1;
        settle();
        access(0, 0, 16'h0300, 16'h0, 0);
        check("routed select", 0, sel_c);
        check("routed flag", 1, ex_c > 0);
        $display("transparent test over");
        report_and_stop();
    end
endmodule // test_buffered_ram_port
`default_nettype wire
